// ==== core/otp_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "otp_map.svh"

// Contract
// R1 - mode zero passes converter samples unchanged; the code applies the output format to them
// R2 - 0001 outputs midscale, format applied
// R3 - 0010 all ones, 0011 all zeros
// R4 - 0100 checkerboard alternates, no format
// R5 - 0101 long pn, 0110 short pn
// R6 - 0111 toggles ones and zeros words
// R7 - 1000 first word from user pattern one
// R8 - user mode second word from pattern two
// R9 - 1001 bit toggle word aaa
// R10 - 1010 outputs sync word 03f
// R11 - 1011 outputs msb-only word
// R12 - 1100 mixed word, higher codes undefined
// R13 - only mid, full-scale, pn formatted; the code also formats mode zero and undefined codes
// R14 - tune bit self-clears when tuning done
// R15 - 0x2c bit0 selects input termination
// R16 - 0x18 reference select and level
// R17 - pn restarts from seed on entry
module otp_regs #(
    parameter int TUNE_CYC = (`OTP_TUNE_NS + `OTP_CLK_NS - 1) / `OTP_CLK_NS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port from serial configuration logic
    input wire otp_pkg::otp_wr_s wr,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    // mode and format from the output mode registers
    input wire logic [3:0] test_mode,
    input wire logic twos_comp,
    // converter samples
    input wire otp_pkg::otp_smp_s adc_in,
    // sample stream to capture logic
    output otp_pkg::otp_smp_s smp_out,
    // analog controls
    output logic ref_external,
    output logic [1:0] ref_level,
    output logic term_high_z,
    output logic tune_start,
    output logic tune_busy
);

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [7:0] ref_q, ref_d; // reference select
    logic [7:0] up1l_q, up1l_d; // user pattern one low
    logic [7:0] up1h_q, up1h_d; // user pattern one high
    logic [7:0] up2l_q, up2l_d; // user pattern two low
    logic [7:0] up2h_q, up2h_d; // user pattern two high
    logic [7:0] tune_q, tune_d; // filter autotune control
    logic [7:0] term_q, term_d; // input termination select
    logic [15:0] tcnt_q, tcnt_d; // tuning timer
    logic [7:0] rd_q, rd_d; // read data

    // write decode helper
    function automatic logic hit(input otp_pkg::otp_wr_s w, input logic [7:0] a);
        hit = w.we && (w.addr == a);
    endfunction

    // next register values and tuning sequencer
    always_comb
    begin
        ref_d = hit(wr, `OTP_OFS_REF_SEL) ? wr.data : ref_q; // [R16]
        up1l_d = hit(wr, `OTP_OFS_UP1_LO) ? wr.data : up1l_q; // [R7]
        up1h_d = hit(wr, `OTP_OFS_UP1_HI) ? wr.data : up1h_q; // [R7]
        up2l_d = hit(wr, `OTP_OFS_UP2_LO) ? wr.data : up2l_q; // [R8]
        up2h_d = hit(wr, `OTP_OFS_UP2_HI) ? wr.data : up2h_q; // [R8]
        term_d = hit(wr, `OTP_OFS_TERM) ? wr.data : term_q; // [R15]
        tune_d = tune_q;
        tcnt_d = tcnt_q;
        if (hit(wr, `OTP_OFS_TUNE))
        begin
            // a fresh start restarts the timer; other bits just store
            tune_d = wr.data;
            if (wr.data[`OTP_BIT_TUNE_GO])
            begin
                tcnt_d = 16'(TUNE_CYC);
            end
        end
        else if (tune_q[`OTP_BIT_TUNE_GO])
        begin
            // hardware clears the go bit when tuning completes
            if (tcnt_q <= 16'h0001)
            begin
                tune_d[`OTP_BIT_TUNE_GO] = 1'b0; // [R14]
                tcnt_d = 16'h0000;
            end
            else
            begin
                tcnt_d = tcnt_q - 16'h0001;
            end
        end
        // read mux, unmapped offsets read zero
        case (rd_addr)
            `OTP_OFS_REF_SEL: rd_d = ref_q;
            `OTP_OFS_UP1_LO: rd_d = up1l_q;
            `OTP_OFS_UP1_HI: rd_d = up1h_q;
            `OTP_OFS_UP2_LO: rd_d = up2l_q;
            `OTP_OFS_UP2_HI: rd_d = up2h_q;
            `OTP_OFS_TUNE: rd_d = tune_q;
            `OTP_OFS_TERM: rd_d = term_q;
            default: rd_d = 8'h00;
        endcase
    end

    // register the file
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ref_q <= `OTP_RST_REF_SEL;
            up1l_q <= `OTP_RST_UP;
            up1h_q <= `OTP_RST_UP;
            up2l_q <= `OTP_RST_UP;
            up2h_q <= `OTP_RST_UP;
            tune_q <= `OTP_RST_TUNE; // [R14]
            term_q <= `OTP_RST_TERM;
            tcnt_q <= 16'h0000;
            rd_q <= 8'h00;
        end
        else
        begin
            ref_q <= ref_d;
            up1l_q <= up1l_d;
            up1h_q <= up1h_d;
            up2l_q <= up2l_d;
            up2h_q <= up2h_d;
            tune_q <= tune_d;
            term_q <= term_d;
            tcnt_q <= tcnt_d;
            rd_q <= rd_d;
        end
    end

    // ----------------------------------------
    // analog control outputs
    // ----------------------------------------
    logic ctl_ext_q, ctl_hi_q, tstart_q, tbusy_q;
    logic [1:0] ctl_lvl_q;

    // registered so every output leaves from a flip-flop
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctl_ext_q <= 1'b0;
            ctl_lvl_q <= 2'b11;
            ctl_hi_q <= 1'b0;
            tstart_q <= 1'b0;
            tbusy_q <= 1'b0;
        end
        else
        begin
            ctl_ext_q <= ref_q[`OTP_BIT_REF_EXT]; // [R16]
            ctl_lvl_q <= ref_q[1:0]; // [R16]
            ctl_hi_q <= term_q[`OTP_BIT_TERM_HI]; // [R15]
            tstart_q <= hit(wr, `OTP_OFS_TUNE) && wr.data[`OTP_BIT_TUNE_GO];
            tbusy_q <= tune_d[`OTP_BIT_TUNE_GO];
        end
    end

    assign ref_external = ctl_ext_q;
    assign ref_level = ctl_lvl_q;
    assign term_high_z = ctl_hi_q;
    assign tune_start = tstart_q;
    assign tune_busy = tbusy_q;
    assign rd_data = rd_q;

    // ----------------------------------------
    // test pattern generator
    // ----------------------------------------
    otp_pkg::otp_mode_e mode;
    logic [3:0] mode_prev_q; // mode seen on the previous clock cycle
    logic phase_q, phase_d; // word one or word two
    logic pnl_rst, pns_rst; // reseed on mode entry
    logic [11:0] pnl_w, pns_w; // pn words
    logic [11:0] pat; // raw pattern word
    logic phase_now; // phase that the current sample takes
    logic fmt_ok; // format conversion allowed
    logic [11:0] fmt_w; // formatted word
    otp_pkg::otp_smp_s out_q, out_d;

    assign mode = otp_pkg::otp_mode_e'(test_mode);
    assign pnl_rst = (mode == otp_pkg::OTP_M_PNL) && (mode_prev_q != test_mode); // [R17]
    assign pns_rst = (mode == otp_pkg::OTP_M_PNS) && (mode_prev_q != test_mode); // [R17]
    // a sample landing on a mode change takes word one rather than the stale phase
    assign phase_now = (mode_prev_q != test_mode) ? 1'b0 : phase_q;

    otp_pn_gen #(.W(23), .TAP(18), .SEED(`OTP_SEED_LONG)) u_pnl (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(pnl_rst),
        .step(adc_in.vld),
        .word(pnl_w)
    );

    otp_pn_gen #(.W(9), .TAP(5), .SEED(`OTP_SEED_SHORT)) u_pns (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(pns_rst),
        .step(adc_in.vld),
        .word(pns_w)
    );

    // pick the raw word for the current mode and phase
    always_comb
    begin
        fmt_ok = 1'b0;
        case (mode)
            otp_pkg::OTP_M_MID:
            begin
                pat = `OTP_W_MID; // [R2]
                fmt_ok = 1'b1;
            end
            otp_pkg::OTP_M_POS:
            begin
                pat = `OTP_W_ONES; // [R3]
                fmt_ok = 1'b1;
            end
            otp_pkg::OTP_M_NEG:
            begin
                pat = `OTP_W_ZERO; // [R3]
                fmt_ok = 1'b1;
            end
            otp_pkg::OTP_M_CHK: pat = phase_now ? `OTP_W_CHK_B : `OTP_W_CHK_A; // [R4]
            otp_pkg::OTP_M_PNL:
            begin
                pat = pnl_w; // [R5]
                fmt_ok = 1'b1;
            end
            otp_pkg::OTP_M_PNS:
            begin
                pat = pns_w; // [R5]
                fmt_ok = 1'b1;
            end
            otp_pkg::OTP_M_WTG: pat = phase_now ? `OTP_W_ZERO : `OTP_W_ONES; // [R6]
            otp_pkg::OTP_M_USR: pat = phase_now ? {up2h_q[3:0], up2l_q} : {up1h_q[3:0], up1l_q}; // [R7] [R8]
            otp_pkg::OTP_M_BTG: pat = `OTP_W_CHK_A; // [R9]
            otp_pkg::OTP_M_SYN: pat = `OTP_W_SYNC; // [R10]
            otp_pkg::OTP_M_ONE: pat = `OTP_W_MSB; // [R11]
            otp_pkg::OTP_M_MIX: pat = `OTP_W_MIXED; // [R12]
            // off and undefined codes pass the converter sample
            default:
            begin
                pat = adc_in.word; // [R1] [R12]
                fmt_ok = 1'b1;
            end
        endcase
    end

    otp_out_fmt u_fmt (
        .twos_comp(twos_comp),
        .apply(fmt_ok),
        .din(pat),
        .dout(fmt_w)
    );

    // advance phase once per sample; restart at word one on mode change
    always_comb
    begin
        phase_d = phase_q;
        out_d = out_q;
        out_d.vld = adc_in.vld;
        if (adc_in.vld)
        begin
            out_d.word = fmt_w; // [R13]
            phase_d = ~phase_q;
        end
        if (mode_prev_q != test_mode)
        begin
            phase_d = adc_in.vld;
        end
    end

    // register the stream and mode tracker
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            out_q <= '0;
            phase_q <= 1'b0;
            mode_prev_q <= `OTP_RST_MODE;
        end
        else
        begin
            out_q <= out_d;
            phase_q <= phase_d;
            mode_prev_q <= test_mode;
        end
    end

    assign smp_out = out_q;

endmodule

`default_nettype wire

// ==== core/otp_map.svh ====
`ifndef OTP_MAP_SVH
`define OTP_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OTP_OFS_REF_SEL 8'h18
`define OTP_OFS_UP1_LO 8'h19
`define OTP_OFS_UP1_HI 8'h1a
`define OTP_OFS_UP2_LO 8'h1b
`define OTP_OFS_UP2_HI 8'h1c
`define OTP_OFS_TUNE 8'h2b
`define OTP_OFS_TERM 8'h2c

// ----------------------------------------
// reset values
// ----------------------------------------
`define OTP_RST_REF_SEL 8'h03
`define OTP_RST_UP 8'h00
`define OTP_RST_TUNE 8'h00
`define OTP_RST_TERM 8'h00
`define OTP_RST_MODE 4'h0

// ----------------------------------------
// field positions
// ----------------------------------------
`define OTP_BIT_REF_EXT 6
`define OTP_BIT_TUNE_GO 6
`define OTP_BIT_TERM_HI 0

// ----------------------------------------
// fixed pattern words
// ----------------------------------------
`define OTP_W_MID 12'h800
`define OTP_W_ONES 12'hfff
`define OTP_W_ZERO 12'h000
`define OTP_W_CHK_A 12'haaa
`define OTP_W_CHK_B 12'h555
`define OTP_W_SYNC 12'h03f
`define OTP_W_MSB 12'h800
`define OTP_W_MIXED 12'ha33

// ----------------------------------------
// pn seeds and tuning time
// ----------------------------------------
`define OTP_SEED_LONG 23'h7fffff
`define OTP_SEED_SHORT 9'h1ff
`define OTP_TUNE_NS 1000
`define OTP_CLK_NS 5

`endif

// ==== core/otp_pkg.sv ====
package otp_pkg;

    // test output modes
    typedef enum logic [3:0] {
        OTP_M_OFF = 4'b0000,
        OTP_M_MID = 4'b0001,
        OTP_M_POS = 4'b0010,
        OTP_M_NEG = 4'b0011,
        OTP_M_CHK = 4'b0100,
        OTP_M_PNL = 4'b0101,
        OTP_M_PNS = 4'b0110,
        OTP_M_WTG = 4'b0111,
        OTP_M_USR = 4'b1000,
        OTP_M_BTG = 4'b1001,
        OTP_M_SYN = 4'b1010,
        OTP_M_ONE = 4'b1011,
        OTP_M_MIX = 4'b1100
    } otp_mode_e;

    // register write strobe with address and data
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } otp_wr_s;

    // sample word with its valid
    typedef struct packed {
        logic vld;
        logic [11:0] word;
    } otp_smp_s;

endpackage

// ==== core/otp_pn_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// pseudo-noise generator, fibonacci lfsr
// ----------------------------------------
module otp_pn_gen #(
    parameter int W = 23,
    parameter int TAP = 18,
    parameter logic [W-1:0] SEED = '1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic restart,
    input wire logic step,
    // output
    output logic [11:0] word
);

    logic [W-1:0] sr_q; // shift register state
    logic [W-1:0] sr_d; // next state
    logic [2*W-1:0] sr_twice; // state laid twice so a register shorter than a word still fills it

    // next state: reseed wins over stepping so entry is deterministic
    always_comb
    begin
        sr_d = sr_q;
        if (restart)
        begin
            sr_d = SEED; // [R17]
        end
        else if (step)
        begin
            sr_d = {sr_q[W-2:0], sr_q[W-1] ^ sr_q[TAP-1]};
        end
    end

    // register state
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sr_q <= '1;
        end
        else
        begin
            sr_q <= sr_d;
        end
    end

    // low twelve bits form the sample word; a short register repeats itself, so W must be six or more
    assign sr_twice = {sr_q, sr_q};
    assign word = sr_twice[11:0];

endmodule

`default_nettype wire

// ==== core/otp_out_fmt.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// output data format conversion
// ----------------------------------------
module otp_out_fmt (
    // control
    input wire logic twos_comp,
    input wire logic apply,
    // data
    input wire logic [11:0] din,
    output logic [11:0] dout
);

    // offset binary to twos complement is an msb flip
    always_comb
    begin
        if (apply && twos_comp)
        begin
            dout = {~din[11], din[10:0]}; // [R13]
        end
        else
        begin
            dout = din;
        end
    end

endmodule

`default_nettype wire

// ==== verif/otp_cap.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// capture side: keeps every valid word
// ----------------------------------------
module otp_cap (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // sample stream from the block
    input wire otp_pkg::otp_smp_s smp_out
);
    // captured words, emptied by the bench before each burst
    logic [11:0] q [$];

    // the word is only trusted on its valid cycle; taken mid-cycle, well away from the launching edge
    always @(negedge sys_clk)
    begin
        if (!rst && smp_out.vld)
        begin
            q.push_back(smp_out.word);
        end
    end
endmodule

`default_nettype wire

// ==== verif/otp_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// port checker for the pattern block
// ----------------------------------------
module otp_regs_asserts #(
    parameter int TUNE_CYC = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register writes and mode
    input wire otp_pkg::otp_wr_s wr,
    input wire logic [3:0] test_mode,
    input wire logic twos_comp,
    // sample streams
    input wire otp_pkg::otp_smp_s adc_in,
    input wire otp_pkg::otp_smp_s smp_out,
    // controls
    input wire logic term_high_z,
    input wire logic tune_start,
    input wire logic tune_busy
);
    // slack covers the write and clear latency around the tuning time
    localparam int TB = TUNE_CYC + 4;
    // word seen when the format flips the msb
    logic [11:0] msb_flip;
    assign msb_flip = {twos_comp, 11'h000};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // tuning steps: request, then pulse with busy
    sequence s_tune_wr;
        wr.we && wr.addr == 8'h2b && wr.data[6];
    endsequence
    sequence s_tune_ack;
        ##[1:2] (tune_start && tune_busy);
    endsequence
    // an all-ones word made in toggle mode, with the next sample arriving
    sequence s_ones;
        smp_out.vld && smp_out.word == 12'hfff && adc_in.vld && test_mode == 4'h7 && $past(test_mode) == 4'h7;
    endsequence
    // termination follows the written bit once the write has landed
    property p_term;
        logic b;
        (wr.we && wr.addr == 8'h2c, b = wr.data[0]) ##1 (!wr.we)[*2] |-> term_high_z == b;
    endproperty

    a_tune_start: assert property (s_tune_wr |-> s_tune_ack)
        else $error("tuning did not start");
    a_tune_clear: assert property ($rose(tune_busy) |-> ##[1:TB] !tune_busy)
        else $error("tuning bit did not clear");
    a_off_pass: assert property (adc_in.vld && test_mode == 4'h0 |=>
        smp_out.vld && smp_out.word == ($past(adc_in.word) ^ $past(msb_flip))) else $error("sample not passed");
    a_mid_fmt: assert property (adc_in.vld && test_mode == 4'h1 |=>
        smp_out.vld && smp_out.word == (12'h800 ^ $past(msb_flip))) else $error("midscale word wrong");
    a_neg_fmt: assert property (adc_in.vld && test_mode == 4'h3 |=>
        smp_out.vld && smp_out.word == (12'h000 ^ $past(msb_flip))) else $error("zero word wrong");
    a_sync_raw: assert property (adc_in.vld && test_mode == 4'ha |=> smp_out.word == 12'h03f)
        else $error("sync word wrong");
    a_msb_raw: assert property (adc_in.vld && test_mode == 4'hb |=> smp_out.word == 12'h800)
        else $error("msb word wrong");
    a_mix_raw: assert property (adc_in.vld && test_mode == 4'hc |=> smp_out.word == 12'ha33)
        else $error("mixed word wrong");
    a_word_toggle: assert property (s_ones |=> smp_out.vld && smp_out.word == 12'h000)
        else $error("toggle did not alternate");
    a_term_sel: assert property (p_term)
        else $error("termination not following register");
endmodule

bind otp_regs otp_regs_asserts #(.TUNE_CYC(TUNE_CYC)) otp_regs_asserts_inst (.sys_clk(sys_clk), .rst(rst),
    .wr(wr), .test_mode(test_mode), .twos_comp(twos_comp), .adc_in(adc_in), .smp_out(smp_out),
    .term_high_z(term_high_z), .tune_start(tune_start), .tune_busy(tune_busy));

`default_nettype wire

// ==== verif/otp_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// one compare: counts it, reports a mismatch at once
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module otp_regs_tb;
    // short tuning time keeps the run small
    localparam int TUNE = 8;
    logic sys_clk;
    logic rst;
    otp_pkg::otp_wr_s wr;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic [3:0] test_mode;
    logic twos_comp;
    otp_pkg::otp_smp_s adc_in;
    otp_pkg::otp_smp_s smp_out;
    logic ref_external;
    logic [1:0] ref_level;
    logic term_high_z;
    logic tune_start;
    logic tune_busy;
    int err_count;
    int n_tests;
    logic [11:0] pn_a [$];
    logic [11:0] e;
    logic [22:0] lf; // long pn reference register
    // pattern table: code, first word, second word, format applies (input word is 123)
    logic [3:0] m_code [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
    logic [11:0] m_w1 [11] = '{12'h123, 12'h800, 12'hfff, 12'h000, 12'haaa, 12'hfff, 12'h234, 12'haaa, 12'h03f,
        12'h800, 12'ha33};
    logic [11:0] m_w2 [11] = '{12'h123, 12'h800, 12'hfff, 12'h000, 12'h555, 12'h000, 12'hbcd, 12'haaa, 12'h03f,
        12'h800, 12'ha33};
    logic m_fmt [11] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    otp_regs #(.TUNE_CYC(TUNE)) otp_regs_inst (.sys_clk(sys_clk), .rst(rst), .wr(wr), .rd_addr(rd_addr),
        .rd_data(rd_data), .test_mode(test_mode), .twos_comp(twos_comp), .adc_in(adc_in), .smp_out(smp_out),
        .ref_external(ref_external), .ref_level(ref_level), .term_high_z(term_high_z),
        .tune_start(tune_start), .tune_busy(tune_busy));
    otp_cap otp_cap_inst (.sys_clk(sys_clk), .rst(rst), .smp_out(smp_out));

    // ----------------------------------------
    // clock and access tasks
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // write strobe stands for exactly one edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        wr = '{we: 1'b1, addr: a, data: d};
        @(negedge sys_clk);
        wr.we = 1'b0;
    endtask

    // read data is registered, so look one cycle later
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
        @(negedge sys_clk);
        rd_addr = a;
        @(negedge sys_clk);
        `CHK(rd_data, x)
    endtask

    // mode changes only while no sample is in flight
    task automatic set_mode(input logic [3:0] m, input logic t);
        @(negedge sys_clk);
        test_mode = m;
        twos_comp = t;
    endtask

    // back-to-back samples; the capture model collects the answers
    task automatic burst(input int n);
        otp_cap_inst.q.delete();
        repeat (n)
        begin
            @(negedge sys_clk);
            adc_in = '{vld: 1'b1, word: 12'h123};
        end
        @(negedge sys_clk);
        adc_in.vld = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        complete_run();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        wr = '0;
        rd_addr = 8'h00;
        test_mode = 4'h0;
        twos_comp = 1'b0;
        adc_in = '0;
        err_count = 0;
        n_tests = 0;
        rst = 1'b1;
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        // defaults
        rd_chk(8'h18, 8'h03);
        for (int a = 8'h19; a <= 8'h1c; a++) rd_chk(8'(a), 8'h00);
        rd_chk(8'h2b, 8'h00);
        rd_chk(8'h2c, 8'h00);
        `CHK({ref_external, ref_level}, 3'h3)
        // writes, an unmapped one among them
        wr_reg(8'h18, 8'h41);
        wr_reg(8'h2c, 8'h01);
        wr_reg(8'h19, 8'h34);
        wr_reg(8'h1a, 8'h12);
        wr_reg(8'h1b, 8'hcd);
        wr_reg(8'h1c, 8'hab);
        wr_reg(8'h20, 8'h5a);
        rd_chk(8'h18, 8'h41);
        rd_chk(8'h1a, 8'h12);
        rd_chk(8'h1c, 8'hab);
        rd_chk(8'h20, 8'h00);
        `CHK({ref_external, ref_level, term_high_z}, 4'hb)
        // every fixed pattern, both formats
        for (int i = 0; i < 11; i++)
        begin
            for (int t = 0; t < 2; t++)
            begin
                set_mode(m_code[i], t[0]);
                burst(4);
                for (int k = 0; k < 4; k++)
                begin
                    e = (k[0] ? m_w2[i] : m_w1[i]) ^ {m_fmt[i] & t[0], 11'h000};
                    `CHK(otp_cap_inst.q[k], e)
                end
            end
        end
        // pn: same sequence on re-entry, msb flipped by the format
        for (int m = 5; m < 7; m++)
        begin
            set_mode(4'(m), 1'b0);
            burst(6);
            pn_a = otp_cap_inst.q;
            `CHK(pn_a[0] !== pn_a[1], 1'b1)
            // long sequence against its own reference: all-ones seed, taps 23 and 18
            lf = 23'h7fffff;
            for (int k = 0; k < 6 && m == 5; k++)
            begin
                `CHK(pn_a[k], lf[11:0])
                lf = {lf[21:0], lf[22] ^ lf[17]};
            end
            set_mode(4'h0, 1'b0);
            set_mode(4'(m), 1'b1);
            burst(6);
            for (int k = 0; k < 6; k++) `CHK(otp_cap_inst.q[k], pn_a[k] ^ 12'h800)
        end
        // undefined codes fall back to samples
        set_mode(4'hd, 1'b0);
        burst(2);
        `CHK(otp_cap_inst.q[0], 12'h123)
        // tuning runs out and clears itself
        wr_reg(8'h2b, 8'h40);
        `CHK(tune_busy, 1'b1)
        `CHK(tune_start, 1'b1)
        @(negedge sys_clk);
        `CHK(tune_start, 1'b0)
        for (int i = 0; i < TUNE + 8 && tune_busy !== 1'b0; i++) @(negedge sys_clk);
        `CHK(tune_busy, 1'b0)
        rd_chk(8'h2b, 8'h00);
        // tuning aborted by writing zero
        wr_reg(8'h2b, 8'h40);
        wr_reg(8'h2b, 8'h00);
        @(negedge sys_clk);
        `CHK(tune_busy, 1'b0)
        wr_reg(8'h2c, 8'h00);
        repeat (2) @(negedge sys_clk);
        `CHK(term_high_z, 1'b0)
        // a second reset in mid-run brings the defaults back
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        rd_chk(8'h18, 8'h03);
        rd_chk(8'h1a, 8'h00);
        `CHK({ref_external, ref_level}, 3'h3)
        complete_run();
    end
endmodule

`default_nettype wire
